// ---- src/idreg_pkg.sv ----
// Constants and carriers for the identification and top config registers.
// Assumes a word-addressed plain register port with byte offsets.
package idreg_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_ID_TWO    = 8'h08;
   localparam logic [7:0] OFF_ID_THREE  = 8'h0c;
   localparam logic [7:0] OFF_ID_FOUR   = 8'h10;
   localparam logic [7:0] OFF_ID_FIVE   = 8'h14;
   localparam logic [7:0] OFF_ID_SIX    = 8'h18;
   localparam logic [7:0] OFF_ID_SEVEN  = 8'h1c;
   localparam logic [7:0] OFF_AUX_CFG   = 8'h20;
   localparam logic [7:0] OFF_AUX_ALIAS = 8'h24;
   localparam logic [7:0] OFF_TOP_CFG   = 8'h28;

   // Capability register two, revision and top config field positions
   localparam int POS_PAN_SUP    = 30;
   localparam int POS_COMPIDX    = 29;
   localparam int POS_HIER_ATTR  = 28;
   localparam int POS_HOST_EXT   = 27;
   localparam int POS_GRP_LO     = 16;
   localparam int POS_WIDE_VMID  = 15;
   localparam int POS_G64K       = 14;
   localparam int POS_G16K       = 13;
   localparam int POS_G4K        = 12;
   localparam int POS_UBS_LO     = 8;
   localparam int POS_OAS_LO     = 4;
   localparam int POS_IAS_LO     = 0;
   localparam int POS_MAJOR_LO   = 4;
   localparam int POS_BYP_SEC_LO = 28;

   // Codes and reset values
   localparam logic [3:0]  WIDTH_CODE_MAX = 4'h5;
   localparam logic [3:0]  UBS_CODE_64    = 4'hf;
   localparam logic [10:0] OVERLAY_GROUPS = 11'h080;
   localparam logic [1:0]  PCFG_PAN       = 2'h1;
   localparam logic [1:0]  PCFG_PRIV      = 2'h3;
   localparam logic [1:0]  BYP_DEFAULT    = 2'h0;
   localparam logic [1:0]  BYP_SECURE     = 2'h2;
   localparam logic [1:0]  BYP_NONSECURE  = 2'h3;
   localparam logic [31:0] AUX_RESET      = 32'h0000_0000;
   localparam logic [27:0] TOP_LOW_RESET  = 28'h000_0000;
   localparam logic [1:0]  BYP_SEC_RESET  = 2'h0;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
      logic        secure;
   } reg_req_t;

   // Transaction context for privilege resolution
   typedef struct packed {
      logic       valid;
      logic [1:0] privilege_configuration;
      logic       bypass_bank;
      logic       hypervisor_context_bank;
      logic       monitor_context_bank;
      logic       region_unpriv;
   } priv_ctx_t;

endpackage : idreg_pkg

// ---- src/privilege_configuration_resolve.sv ----
// Resolves the effective privilege setting of one transaction.
// Assumes context fields are stable in the cycle they are valid.
`timescale 1ns/1ps
module privilege_configuration_resolve
   import idreg_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Capability and context
   input  wire logic       priv_access_never_support,
   input  wire priv_ctx_t  ctx,
   // Result
   output logic [1:0]      eff_privilege_configuration,
   output logic            perm_fault
);

   wire       pan_code  = priv_access_never_support &
                          (ctx.privilege_configuration == PCFG_PAN);
   wire       no_levels = ctx.hypervisor_context_bank |
                          ctx.monitor_context_bank;
   wire       two_level = ~ctx.bypass_bank & ~no_levels;
   // Redefined code acts as privileged everywhere
   wire [1:0] eff_nxt   = pan_code ? PCFG_PRIV :
                          ctx.privilege_configuration; // see R1 R2 R3
   wire       fault_nxt = ctx.valid & pan_code & two_level &
                          ctx.region_unpriv; // see R1

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eff_privilege_configuration <= 2'h0;
         perm_fault  <= 1'b0;
      end else begin
         eff_privilege_configuration <= eff_nxt;
         perm_fault  <= fault_nxt;
      end
   end

endmodule : privilege_configuration_resolve

// ---- src/iommu_id_and_top_config_regs.sv ----
// Capability identification, auxiliary and top-level config registers.
// Assumes a plain register port with read data one cycle after the strobe.
//
// Function
// R1 - Code 01 forces privileged, faults unprivileged regions
// R2 - Bypass banks treat code 01 as 11
// R3 - Hypervisor and monitor banks: 01 equals 11
// R4 - Compressed index bit hidden from Non-secure
// R5 - Bit 28 reports hierarchical attribute disable
// R6 - Bit 27 reports host-extension context
// R7 - Group count depends on access security
// R8 - Group count includes 128 overlay groups
// R9 - Group count zero without extended matching
// R10 - Bit 15 reports wide VM identifiers
// R11 - Bits 14..12 report granule support
// R12 - Upstream width codes 0..5 or 15
// R13 - Output width codes 0..5
// R14 - Intermediate width codes 0..5
// R15 - Register seven holds major, minor revision
// R16 - Auxiliary register banked, 32-bit read-write
// R17 - Top config banked per security state
// R18 - Bypass attribute only in Secure copy
// R19 - Bypass attribute codes steer transaction security
// R20 - Stream indexing only without stream matching
// R21 - Identification registers read-only constants
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module iommu_id_and_top_config_regs
   import idreg_pkg::*;
#(
   parameter bit          TWO_SEC_STATES  = 1'b1,
   parameter bit          PAN_SUPPORT     = 1'b1,
   parameter bit          COMPIDX_SUPPORT = 1'b1,
   parameter bit          HIER_ATTR_SUP   = 1'b1,
   parameter bit          HOST_EXT_SUP    = 1'b0,
   parameter bit          EXT_MATCH_SUP   = 1'b1,
   parameter logic [10:0] EXT_GROUPS      = 11'h100,
   parameter bit          WIDE_VMID_SUP   = 1'b1,
   parameter bit          G64K_SUP        = 1'b1,
   parameter bit          G16K_SUP        = 1'b0,
   parameter bit          G4K_SUP         = 1'b1,
   parameter logic [3:0]  UBS_CODE        = 4'h2,
   parameter logic [3:0]  OAS_CODE        = 4'h2,
   parameter logic [3:0]  IAS_CODE        = 4'h2,
   parameter logic [3:0]  REV_MAJOR       = 4'h1,
   parameter logic [3:0]  REV_MINOR       = 4'h0,
   parameter bit          STREAM_MATCH    = 1'b1
)(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // Register port
   input  wire reg_req_t    REQ,
   output logic [31:0]      RDATA,
   // Secure controls from elsewhere
   input  wire logic        NS_COMPIDX_OFF,
   input  wire logic [10:0] NS_EXT_GROUPS,
   // Transaction privilege context
   input  wire priv_ctx_t   PRIV_CTX,
   output logic [1:0]       EFF_PRIVILEGE_CONFIGURATION,
   output logic             PERM_FAULT,
   // Secure bypass transaction
   input  wire logic        BYP_VALID,
   input  wire logic        BYP_DEFAULT_NS,
   output logic            BYP_NS,
   // Capability status
   output logic             STREAM_INDEX_EN
);

   // Width code legality
   function automatic logic [3:0] width_code(input logic [3:0] c,
                                             input logic allow64);
      logic ok;
      ok = (c <= WIDTH_CODE_MAX) | (allow64 & (c == UBS_CODE_64));
      return ok ? c : 4'h0;
   endfunction : width_code

   // Constant capability values
   localparam logic [3:0] UBS_V = width_code(UBS_CODE, 1'b1); // see R12
   localparam logic [3:0] OAS_V = width_code(OAS_CODE, 1'b0); // see R13
   localparam logic [3:0] IAS_V = width_code(IAS_CODE, 1'b0); // see R14
   localparam logic [10:0] GRP_TOTAL =
      !EXT_MATCH_SUP ? 11'h000 :                     // see R9
      (EXT_GROUPS < OVERLAY_GROUPS) ? OVERLAY_GROUPS : // see R8
      EXT_GROUPS;

   // Access decode
   wire        eff_sec    = TWO_SEC_STATES ? REQ.secure : 1'b1;
   wire        hit_id2    = REQ.addr == OFF_ID_TWO;
   wire        hit_id7    = REQ.addr == OFF_ID_SEVEN;
   wire        hit_idrsv  = (REQ.addr == OFF_ID_THREE) |
                            (REQ.addr == OFF_ID_FOUR) |
                            (REQ.addr == OFF_ID_FIVE) |
                            (REQ.addr == OFF_ID_SIX);
   wire        hit_aux    = REQ.addr == OFF_AUX_CFG;
   wire        hit_alias  = (REQ.addr == OFF_AUX_ALIAS) & eff_sec &
                            TWO_SEC_STATES;
   wire        hit_top    = REQ.addr == OFF_TOP_CFG;

   // Bank selection
   wire        aux_s_sel  = hit_aux & eff_sec;
   wire        aux_ns_sel = (hit_aux & ~eff_sec) | hit_alias; // see R16
   wire        top_s_sel  = hit_top & eff_sec;                // see R17
   wire        top_ns_sel = hit_top & ~eff_sec;

   // Register state
   logic [31:0] aux_s_r;
   logic [31:0] aux_ns_r;
   logic [27:0] top_s_low_r;
   logic [27:0] top_ns_low_r;
   logic [1:0]  byp_sec_r;
   logic [31:0] rdata_r;

   // Capability register two, security dependent
   wire        compidx_rd = COMPIDX_SUPPORT &
                            (eff_sec | ~NS_COMPIDX_OFF); // see R4
   wire [10:0] ns_grp     = (NS_EXT_GROUPS > GRP_TOTAL) ? GRP_TOTAL :
                            NS_EXT_GROUPS;
   wire [10:0] grp_rd     = eff_sec ? GRP_TOTAL : ns_grp; // see R7
   wire [31:0] id2_val;
   assign id2_val[31]                         = 1'b0;
   assign id2_val[POS_PAN_SUP]                = PAN_SUPPORT;
   assign id2_val[POS_COMPIDX]                = compidx_rd;
   assign id2_val[POS_HIER_ATTR]              = HIER_ATTR_SUP; // see R5
   assign id2_val[POS_HOST_EXT]               = HOST_EXT_SUP;  // see R6
   assign id2_val[POS_GRP_LO +: 11]           = grp_rd;
   assign id2_val[POS_WIDE_VMID]              = WIDE_VMID_SUP; // see R10
   assign id2_val[POS_G64K]                   = G64K_SUP;      // see R11
   assign id2_val[POS_G16K]                   = G16K_SUP;
   assign id2_val[POS_G4K]                    = G4K_SUP;
   assign id2_val[POS_UBS_LO +: 4]            = UBS_V;
   assign id2_val[POS_OAS_LO +: 4]            = OAS_V;
   assign id2_val[POS_IAS_LO +: 4]            = IAS_V;

   // Revision register, upper bits reserved
   wire [31:0] id7_val = {24'h00_0000, REV_MAJOR, REV_MINOR}; // see R15

   // Top config read views; Non-secure copy hides bypass field
   wire [31:0] top_s_val  = {2'h0, byp_sec_r, top_s_low_r};
   wire [31:0] top_ns_val = {4'h0, top_ns_low_r}; // see R18

   // Read mux; identification registers have no write path
   wire [31:0] rd_sel =
      hit_id2    ? id2_val :    // see R21
      hit_id7    ? id7_val :
      hit_idrsv  ? 32'h0000_0000 :
      aux_s_sel  ? aux_s_r :
      aux_ns_sel ? aux_ns_r :
      top_s_sel  ? top_s_val :
      top_ns_sel ? top_ns_val :
      32'h0000_0000;
   wire [31:0] rdata_nxt = REQ.rd ? rd_sel : 32'h0000_0000;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Auxiliary register banks
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         aux_s_r  <= AUX_RESET;
         aux_ns_r <= AUX_RESET;
      end else if (REQ.wr) begin
         if (aux_s_sel) aux_s_r <= REQ.wdata;   // see R16
         if (aux_ns_sel) aux_ns_r <= REQ.wdata;
      end
   end

   // Top config banks
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         top_s_low_r  <= TOP_LOW_RESET;
         top_ns_low_r <= TOP_LOW_RESET;
         byp_sec_r    <= BYP_SEC_RESET; // see R19
      end else if (REQ.wr) begin
         if (top_s_sel) begin
            top_s_low_r <= REQ.wdata[27:0];
            byp_sec_r   <= REQ.wdata[POS_BYP_SEC_LO +: 2]; // see R18
         end
         if (top_ns_sel) top_ns_low_r <= REQ.wdata[27:0]; // see R17
      end
   end

   // Secure bypass attribute steering; reserved code keeps default
   wire byp_ns_nxt =
      (byp_sec_r == BYP_SECURE)    ? 1'b0 :
      (byp_sec_r == BYP_NONSECURE) ? 1'b1 :
      BYP_DEFAULT_NS; // see R19
   logic byp_ns_r;
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         byp_ns_r <= 1'b0;
      end else if (BYP_VALID) begin
         byp_ns_r <= byp_ns_nxt;
      end
   end

   // Privilege resolution
   privilege_configuration_resolve u_privilege_configuration (
      .clk                       (CORE_CLK),
      .rst                       (RST),
      .priv_access_never_support (PAN_SUPPORT),
      .ctx                       (PRIV_CTX),
      .eff_privilege_configuration               (EFF_PRIVILEGE_CONFIGURATION),
      .perm_fault                (PERM_FAULT)
   ); // see R1 R2 R3

   assign RDATA           = rdata_r;
   assign BYP_NS          = byp_ns_r;
   assign STREAM_INDEX_EN = ~STREAM_MATCH; // see R20

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   wire rd_id2_ns = REQ.rd & hit_id2 & ~eff_sec;
   wire rd_top_s  = REQ.rd & top_s_sel;
   wire wr_top_s  = REQ.wr & top_s_sel;
   wire pan_ctx   = PAN_SUPPORT &
                    (PRIV_CTX.privilege_configuration == PCFG_PAN);

   compidx_hide_a: assert property ( // see R4
      rd_id2_ns & NS_COMPIDX_OFF |=> RDATA[POS_COMPIDX] == 1'b0)
      else $error("compressed index visible to Non-secure");

   group_count_a: assert property ( // see R7
      REQ.rd & hit_id2 & eff_sec |=> RDATA[POS_GRP_LO +: 11] == GRP_TOTAL)
      else $error("Secure group count wrong");

   group_ns_a: assert property ( // see R7
      rd_id2_ns |=> RDATA[POS_GRP_LO +: 11] <= GRP_TOTAL)
      else $error("Non-secure group count above total");

   bypass_privilege_configuration_a: assert property ( // see R2
      PRIV_CTX.bypass_bank & pan_ctx |=> EFF_PRIVILEGE_CONFIGURATION == PCFG_PRIV)
      else $error("bypass bank code 01 not privileged");

   hyp_mon_privilege_configuration_a: assert property ( // see R3
      (PRIV_CTX.hypervisor_context_bank | PRIV_CTX.monitor_context_bank)
      & pan_ctx |=> EFF_PRIVILEGE_CONFIGURATION == PCFG_PRIV)
      else $error("hyp or monitor code 01 not privileged");

   pan_fault_a: assert property ( // see R1
      PRIV_CTX.valid & pan_ctx & PRIV_CTX.region_unpriv &
      ~PRIV_CTX.bypass_bank & ~PRIV_CTX.hypervisor_context_bank &
      ~PRIV_CTX.monitor_context_bank |=> PERM_FAULT)
      else $error("missing permission fault");

   ns_field_hide_a: assert property ( // see R18
      REQ.rd & top_ns_sel |=> RDATA[POS_BYP_SEC_LO +: 2] == 2'h0)
      else $error("bypass field visible in Non-secure copy");

   top_bank_a: assert property ( // see R17
      wr_top_s ##1 rd_top_s & ~wr_top_s |=>
      RDATA[POS_BYP_SEC_LO +: 2] == $past(REQ.wdata[29:28], 2))
      else $error("Secure top config readback wrong");

   revision_a: assert property ( // see R15
      REQ.rd & hit_id7 |=> RDATA == {24'h00_0000, REV_MAJOR, REV_MINOR})
      else $error("revision register wrong");

   id_const_a: assert property ( // see R21
      REQ.wr & hit_id2 & eff_sec ##1 REQ.rd & hit_id2 & eff_sec |=>
      RDATA == {1'b0, PAN_SUPPORT, COMPIDX_SUPPORT, HIER_ATTR_SUP,
                HOST_EXT_SUP, GRP_TOTAL, WIDE_VMID_SUP, G64K_SUP,
                G16K_SUP, G4K_SUP, UBS_V, OAS_V, IAS_V})
      else $error("identification register changed by write");

   force_secure_a: assert property ( // see R19
      BYP_VALID & (byp_sec_r == BYP_SECURE) |=> ~BYP_NS)
      else $error("bypass not forced Secure");

   read_idle_a: assert property (
      ~REQ.rd |=> RDATA == 32'h0000_0000)
      else $error("read data outside read cycle");

   cov_ns_id_read: cover property (rd_id2_ns & NS_COMPIDX_OFF);
   cov_top_roundtrip: cover property (wr_top_s ##1 rd_top_s);
   cov_pan_fault: cover property (PERM_FAULT);
   cov_force_ns: cover property (BYP_VALID &
                                 (byp_sec_r == BYP_NONSECURE));

endmodule : iommu_id_and_top_config_regs

// ---- sim/testbench.sv ----
// Self-checking bench for the identification and top config registers.
// Assumes the design package and the register bank module are compiled first.
`timescale 1ns/1ps
module testbench
   import idreg_pkg::*;
;
   // Implementation choices under test
   localparam bit PAN = 1'b1, CIDX = 1'b1, HIER = 1'b1, HOSTX = 1'b1;
   localparam bit EXTM = 1'b1, WVMID = 1'b1, SMATCH = 1'b1;
   localparam bit G64 = 1'b1, G16 = 1'b1, G4 = 1'b0;
   localparam logic [10:0] EXT_G = 11'h0c0;
   localparam logic [3:0] UBSC = 4'hf, OASC = 4'h5, IASC = 4'h3;
   localparam logic [3:0] MAJ = 4'h2, MINR = 4'h7;
   localparam int LIMIT = 20000;

   logic        core_clk;
   logic        rst;
   reg_req_t    req;
   logic [31:0] rdata;
   logic        ns_off;
   logic [10:0] ns_grp;
   priv_ctx_t   ctx;
   logic [1:0]  eff;
   logic        fault;
   logic        byp_valid;
   logic        byp_dns;
   logic        byp_ns;
   logic        sidx_en;
   int          mismatches;
   int          checks_done;
   int          cycles;
   int          seed;
   logic [31:0] v;
   logic [31:0] a;
   logic [31:0] b;
   logic [2:0]  pe;
   logic [7:0]  ids [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40};

   iommu_id_and_top_config_regs #(
      .PAN_SUPPORT(PAN), .COMPIDX_SUPPORT(CIDX), .HIER_ATTR_SUP(HIER),
      .HOST_EXT_SUP(HOSTX), .EXT_MATCH_SUP(EXTM), .EXT_GROUPS(EXT_G),
      .WIDE_VMID_SUP(WVMID), .G64K_SUP(G64), .G16K_SUP(G16), .G4K_SUP(G4),
      .UBS_CODE(UBSC), .OAS_CODE(OASC), .IAS_CODE(IASC),
      .REV_MAJOR(MAJ), .REV_MINOR(MINR), .STREAM_MATCH(SMATCH)
   ) dut (
      .CORE_CLK(core_clk), .RST(rst), .REQ(req), .RDATA(rdata),
      .NS_COMPIDX_OFF(ns_off), .NS_EXT_GROUPS(ns_grp),
      .PRIV_CTX(ctx), .EFF_PRIVILEGE_CONFIGURATION(eff), .PERM_FAULT(fault),
      .BYP_VALID(byp_valid), .BYP_DEFAULT_NS(byp_dns), .BYP_NS(byp_ns),
      .STREAM_INDEX_EN(sidx_en)
   );

   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         mismatches = mismatches + 1;
         test_done();
      end
   end

   function automatic logic [31:0] exp_id2(input logic sec, input logic off,
                                           input logic [10:0] nsg);
      logic [10:0] g;
      g = !EXTM ? 11'h000 : (EXT_G < 11'h080) ? 11'h080 : EXT_G;
      if (!sec && nsg < g) g = nsg;
      return {1'b0, PAN, CIDX & (sec | ~off), HIER, HOSTX, g, WVMID,
              G64, G16, G4, UBSC, OASC, IASC};
   endfunction : exp_id2

   function automatic logic [31:0] exp_reg(input logic [7:0] ad,
                                           input logic sec);
      case (ad)
         OFF_ID_TWO:   return exp_id2(sec, ns_off, ns_grp);
         OFF_ID_SEVEN: return {24'h00_0000, MAJ, MINR};
         default:      return 32'h0000_0000;
      endcase
   endfunction : exp_reg

   function automatic logic [2:0] exp_priv(input priv_ctx_t c);
      logic pan1;
      pan1 = PAN && c.privilege_configuration == PCFG_PAN;
      return {c.valid && pan1 && c.region_unpriv && !(c.bypass_bank ||
              c.hypervisor_context_bank || c.monitor_context_bank),
              pan1 ? PCFG_PRIV : c.privilege_configuration};
   endfunction : exp_priv

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                     input logic s);
      @(posedge core_clk);
      req.addr   <= ad;
      req.wdata  <= d;
      req.secure <= s;
      req.wr     <= 1'b1;
      @(posedge core_clk);
      req.wr     <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic s,
                     output logic [31:0] d);
      @(posedge core_clk);
      req.addr   <= ad;
      req.secure <= s;
      req.rd     <= 1'b1;
      @(posedge core_clk);
      req.rd     <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // Write strobe followed directly by a read strobe to the same place
   task automatic wr_rd(input logic [7:0] ad, input logic [31:0] d,
                        input logic s, output logic [31:0] q);
      @(posedge core_clk);
      req.addr   <= ad;
      req.wdata  <= d;
      req.secure <= s;
      req.wr     <= 1'b1;
      @(posedge core_clk);
      req.wr     <= 1'b0;
      req.rd     <= 1'b1;
      @(posedge core_clk);
      req.rd     <= 1'b0;
      #1 q = rdata;
   endtask : wr_rd

   task automatic reset_chk();
      rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         rd(OFF_AUX_CFG, s[0], v);
         check("aux_reset", v, AUX_RESET);
         rd(OFF_TOP_CFG, s[0], v);
         check("top_reset", v, 32'h0000_0000);
      end
   endtask : reset_chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   initial begin
      seed = 13597;
      mismatches = 0;
      checks_done = 0;
      cycles = 0;
      rst = 1'b1;
      req = '0;
      ns_off = 1'b0;
      ns_grp = 11'h000;
      ctx = '0;
      byp_valid = 1'b0;
      byp_dns = 1'b0;
      reset_chk();
      check("stream_index", sidx_en, !SMATCH);
      // Identification reads, ignored writes, unmapped place
      for (int i = 0; i < 12; i++) begin
         ns_off <= (i < 4) ? i[1] : 1'($random(seed));
         ns_grp <= (i == 0) ? 11'h000 : (i == 2) ? 11'h7ff
                   : 11'($random(seed));
         foreach (ids[k]) begin
            wr_rd(ids[k], $random(seed), i[0], v);
            check("id_reg", v, exp_reg(ids[k], i[0]));
         end
      end
      // Banked auxiliary, its alias, banked top config
      repeat (4) begin
         a = $random(seed);
         b = $random(seed);
         wr(OFF_AUX_CFG, a, 1'b1);
         wr(OFF_AUX_CFG, b, 1'b0);
         rd(OFF_AUX_CFG, 1'b1, v);
         check("aux_sec", v, a);
         rd(OFF_AUX_ALIAS, 1'b1, v);
         check("aux_alias", v, b);
         wr(OFF_AUX_ALIAS, a, 1'b0);
         rd(OFF_AUX_ALIAS, 1'b0, v);
         check("alias_ns", v, 32'h0000_0000);
         wr(OFF_AUX_ALIAS, ~b, 1'b1);
         rd(OFF_AUX_CFG, 1'b0, v);
         check("aux_ns", v, ~b);
         wr_rd(OFF_TOP_CFG, a, 1'b1, v);
         check("top_sec", v, a & 32'h3fff_ffff);
         wr_rd(OFF_TOP_CFG, b, 1'b0, v);
         check("top_ns", v, b & 32'h0fff_ffff);
         rd(OFF_TOP_CFG, 1'b1, v);
         check("top_banked", v, a & 32'h3fff_ffff);
      end
      // Every bypass code with both default attributes
      for (int c = 0; c < 8; c++) begin
         wr(OFF_TOP_CFG, {2'h0, c[1:0], 28'h000_0000}, 1'b1);
         @(posedge core_clk);
         byp_valid <= 1'b1;
         byp_dns   <= c[2];
         @(posedge core_clk);
         byp_valid <= 1'b0;
         #1 check("byp_ns", byp_ns, (c[1:0] == BYP_SECURE) ? 1'b0
                  : (c[1:0] == BYP_NONSECURE) ? 1'b1 : c[2]);
      end
      // Privilege resolution, every code then random contexts
      for (int i = 0; i < 64; i++) begin
         v = $random(seed);
         @(posedge core_clk);
         ctx <= (i < 4) ? {1'b1, i[1:0], 4'h1} : v[6:0];
         @(posedge core_clk);
         #1 pe = exp_priv(ctx);
         check("perm_fault", fault, pe[2]);
         if (ctx.valid === 1'b1)
            check("eff_priv", eff, pe[1:0]);
      end
      reset_chk();
      test_done();
   end
endmodule : testbench
